/* fbr_flash_read_cfg.sv */
// Read configuration register and synchronous burst read control.
`timescale 1ns/1ps
// Summary of operation
// R1 - Bit 15 high selects asynchronous page reads, low selects burst reads.
// R2 - Identifier mode read at offset 0x05 returns read_config.
// R3 - First burst word appears latency clocks after the address capture.
// R4 - Bits 13:11 hold latency codes 2 to 7, default 7.
// R5 - Excess latency with one-clock hold adds stalls after every four words.
// R6 - Bit 10 sets stall asserted level, default high.
// R7 - Stall changes only on active edges during active bus cycles.
// R8 - In burst mode stall stays asserted until data is valid.
// R9 - Asynchronous reads hold stall at its deasserted level.
// R10 - Stall floats when chip select or output enable is high.
// R11 - Bit 9 selects two-clock (default) or one-clock word hold.
// R12 - Host picks one-clock hold only when timing fits one period.
// R13 - Bit 8 deasserts stall one data cycle early (default) or with data.
// R14 - Host must not use early stall with latency 2 and two-clock hold.
// R15 - Bit 7 burst order; only linear value 1 is supported.
// R16 - Bit 6 selects active clock edge, rising by default.
// R17 - Bit 3 low wraps fixed bursts, high runs linearly (default).
// R18 - Bits 2:0 select 4, 8, 16 or continuous (default) burst length.
// R19 - Wrapped bursts count modulo length inside the aligned block.
// R20 - Continuous bursts always run linearly.
// R21 - Command 0x60 then 0x03 loads address bits into read_config.
// R22 - Reset leaves asynchronous page mode with array reads selected.
// R23 - Start address captured on address-valid rise or next active edge.
// R24 - Reset loads all defaults; reserved bits read as zero.
module fbr_flash_read_cfg (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        flashClk,
   input  wire logic        chipSelN,
   input  wire logic        outEnN,
   input  wire logic        writeEnN,
   input  wire logic        addrValidN,
   input  wire logic [15:0] addrIn,
   input  wire logic [15:0] dataIn,
   input  wire logic [15:0] arrayData,
   output logic      [15:0] arrayAddr,
   output logic      [15:0] dataOut,
   output logic             dataOe,
   output logic             stallOut,
   output logic             stallOe,
   output logic      [15:0] readConfig
);

   logic [fbr_pkg::PIN_W-1:0] pinRaw;
   logic [fbr_pkg::PIN_W-1:0] pinSync;

   logic              fclkS;
   logic              csN;
   logic              oeN;
   logic              weN;
   logic              advN;
   logic [15:0]       addrS;
   logic [15:0]       dataS;

   logic              fclkD;
   logic              weD;
   logic              advD;

   fbr_pkg::fbr_cmd_t   cmdState;
   fbr_pkg::fbr_cmd_t   next_cmdState;
   fbr_pkg::fbr_burst_t burst;
   fbr_pkg::fbr_burst_t next_burst;

   logic [2:0]        gapLeft;
   logic [2:0]        next_gapLeft;
   logic [1:0]        holdLeft;
   logic [1:0]        next_holdLeft;
   logic [3:0]        wordCnt;
   logic [3:0]        next_wordCnt;
   logic              loadWord;
   logic              stallWant;
   logic [15:0]       next_readConfig;

   // Pins come from the host's domain and are synchronised first.
   assign pinRaw = {flashClk, chipSelN, outEnN, writeEnN, addrValidN,
                    addrIn, dataIn};

   fbr_pin_sync #(
      .W    (fbr_pkg::PIN_W),
      .INIT (fbr_pkg::PIN_RESET)
   ) uSync (
      .clk     (clk),
      .rst_b   (rst_b),
      .pinRaw  (pinRaw),
      .pinSync (pinSync)
   );

   assign fclkS = pinSync[36];
   assign csN   = pinSync[35];
   assign oeN   = pinSync[34];
   assign weN   = pinSync[33];
   assign advN  = pinSync[32];
   assign addrS = pinSync[31:16];
   assign dataS = pinSync[15:0];

   // Configuration fields.
   logic       syncMode;
   logic [2:0] latRaw;
   logic [2:0] latEff;
   logic       polHigh;
   logic       holdTwo;
   logic       leadEarly;
   logic       edgeRise;
   logic       wrapOn;
   logic [2:0] lenCode;

   // R1 mode bit: a cleared bit enables burst reads.
   assign syncMode  = ~readConfig[fbr_pkg::MODE_BIT];
   // R4 latency field; reserved low codes act as the shortest latency.
   assign latRaw    = readConfig[fbr_pkg::LAT_HI:fbr_pkg::LAT_LO];
   assign latEff    = (latRaw < fbr_pkg::LAT_MIN_CODE) ?
                      fbr_pkg::LAT_MIN_CODE : latRaw;
   // R6 stall polarity.
   assign polHigh   = readConfig[fbr_pkg::POL_BIT];
   // R11 word hold length.
   assign holdTwo   = readConfig[fbr_pkg::HOLD_BIT];
   // R13 stall lead select.
   assign leadEarly = readConfig[fbr_pkg::LEAD_BIT];
   // R16 active edge select.
   assign edgeRise  = readConfig[fbr_pkg::EDGE_BIT];
   // R17 wrap only when the wrap-disable bit is clear.
   assign wrapOn    = ~readConfig[fbr_pkg::WRAP_BIT];
   // R18 burst length code.
   assign lenCode   = readConfig[fbr_pkg::LEN_HI:fbr_pkg::LEN_LO];

   // Edge detection on the synchronised link pins.
   logic fclkRise;
   logic fclkFall;
   logic activeEdge;
   logic advRise;
   logic advFall;
   logic cmdWrite;
   logic busRead;
   logic stallPinOn;

   assign fclkRise   = fclkS & ~fclkD;
   assign fclkFall   = ~fclkS & fclkD;
   // R16 one edge of the link clock drives all burst timing.
   assign activeEdge = edgeRise ? fclkRise : fclkFall;
   assign advRise    = advN & ~advD;
   assign advFall    = ~advN & advD;
   assign cmdWrite   = ~csN & weN & ~weD;
   assign busRead    = ~csN & ~oeN & weN;
   // R10 stall pin driven only with chip select and output enable low.
   assign stallPinOn = ~csN & ~oeN;

   // Burst timing values.
   logic [1:0] holdLen;
   logic [2:0] excess;
   logic [3:0] lenMask;
   logic       fixedLen;
   logic       lastWord;
   logic       groupEnd;
   logic [15:0] stepAddr;
   logic       startBurst;
   logic       abortBurst;
   logic       arrayRead;

   assign holdLen  = holdTwo ? 2'h2 : 2'h1;
   // R5 extra stall clocks per four-word group with one-clock hold.
   assign excess   = (!holdTwo && latEff > fbr_pkg::LAT_RATE_CODE) ?
                     (latEff - fbr_pkg::LAT_RATE_CODE) : 3'h0;
   assign fixedLen = (lenMask != 4'h0);
   assign lastWord = fixedLen && (wordCnt == lenMask);
   assign groupEnd = (wordCnt[1:0] == fbr_pkg::GROUP_LAST);
   assign arrayRead = (cmdState == fbr_pkg::CMD_ARRAY);

   // R15 burst order bit is stored but only linear stepping exists.
   fbr_burst_step uStep (
      .curAddr  (arrayAddr),
      .wrapOn   (wrapOn),
      .lenCode  (lenCode),
      .nextAddr (stepAddr),
      .lenMask  (lenMask)
   );

   // R23 start on address-valid rise or on an active edge while low.
   assign startBurst = (burst == fbr_pkg::BR_IDLE) && syncMode && ~csN &&
                       (advRise || (activeEdge && ~advN));
   assign abortBurst = csN || advFall;

   // R2 identifier space shows read_config at its offset.
   logic [15:0] identData;
   logic [15:0] srcData;

   assign identData = (arrayAddr == fbr_pkg::ID_CFG_OFFSET) ?
                      readConfig : fbr_pkg::ID_FILL;
   assign srcData   = arrayRead ? arrayData : identData;

   // Burst sequencer.
   always_comb begin
      next_burst    = burst;
      next_gapLeft  = gapLeft;
      next_holdLeft = holdLeft;
      next_wordCnt  = wordCnt;
      loadWord      = 1'b0;
      unique case (burst)
         fbr_pkg::BR_IDLE: begin
            if (startBurst) begin
               next_burst   = fbr_pkg::BR_RUN;
               // R3 first word after the latency count of active edges.
               next_gapLeft = latEff;
               next_wordCnt = 4'h0;
            end
         end
         fbr_pkg::BR_RUN, fbr_pkg::BR_DONE: begin
            if (abortBurst) begin
               next_burst = fbr_pkg::BR_IDLE;
            end else if (activeEdge) begin
               if (gapLeft > 3'h1) begin
                  next_gapLeft = gapLeft - 3'h1;
               end else if (gapLeft == 3'h1) begin
                  loadWord      = 1'b1;
                  next_gapLeft  = 3'h0;
                  next_holdLeft = holdLen;
               end else if (holdLeft > 2'h1) begin
                  next_holdLeft = holdLeft - 2'h1;
               end else if (burst == fbr_pkg::BR_RUN) begin
                  if (lastWord) begin
                     // Fixed bursts keep the last word once complete.
                     next_burst = fbr_pkg::BR_DONE;
                  end else if (groupEnd && excess != 3'h0) begin
                     // R5 insert wait clocks before the next group.
                     next_gapLeft = excess;
                     next_wordCnt = wordCnt + 4'h1;
                  end else begin
                     loadWord      = 1'b1;
                     next_holdLeft = holdLen;
                     next_wordCnt  = wordCnt + 4'h1;
                  end
               end
            end
         end
      endcase
   end

   // R8 stall holds until data is valid.
   // R13 early mode releases it one data cycle ahead.
   assign stallWant = (next_burst != fbr_pkg::BR_IDLE) &&
                      (next_gapLeft != 3'h0) &&
                      (!leadEarly || next_gapLeft > {1'b0, holdLen});

   logic stallLevelOn;
   logic stallLevelOff;
   logic stallIdle;

   assign stallLevelOn  = polHigh;
   assign stallLevelOff = ~polHigh;
   assign stallIdle     = syncMode ? stallLevelOn : stallLevelOff;

   // Command interface for the configuration write sequence.
   always_comb begin
      next_cmdState   = cmdState;
      next_readConfig = readConfig;
      if (cmdWrite) begin
         unique case (cmdState)
            fbr_pkg::CMD_SETUP: begin
               next_cmdState = fbr_pkg::CMD_ARRAY;
               // R21 second cycle loads the address into read_config.
               // R24 reserved bits are forced to zero on load.
               if (dataS[7:0] == fbr_pkg::CMD_CFG_WRITE) begin
                  next_readConfig = addrS & fbr_pkg::CFG_KEEP_MASK;
               end
            end
            fbr_pkg::CMD_ARRAY, fbr_pkg::CMD_IDENT: begin
               if (dataS[7:0] == fbr_pkg::CMD_CFG_SETUP) begin
                  next_cmdState = fbr_pkg::CMD_SETUP;
               end else if (dataS[7:0] == fbr_pkg::CMD_READ_IDENT) begin
                  next_cmdState = fbr_pkg::CMD_IDENT;
               end else if (dataS[7:0] == fbr_pkg::CMD_READ_ARRAY) begin
                  next_cmdState = fbr_pkg::CMD_ARRAY;
               end
            end
         endcase
      end
   end

   // R22 reset returns to array reads.
   // R24 reset loads the default configuration.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cmdState   <= fbr_pkg::CMD_ARRAY;
         readConfig <= fbr_pkg::CFG_RESET;
      end else begin
         cmdState   <= next_cmdState;
         readConfig <= next_readConfig;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fclkD <= 1'b0;
         weD   <= 1'b1;
         advD  <= 1'b1;
      end else begin
         fclkD <= fclkS;
         weD   <= weN;
         advD  <= advN;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         burst    <= fbr_pkg::BR_IDLE;
         gapLeft  <= 3'h0;
         holdLeft <= 2'h0;
         wordCnt  <= 4'h0;
      end else begin
         burst    <= next_burst;
         gapLeft  <= next_gapLeft;
         holdLeft <= next_holdLeft;
         wordCnt  <= next_wordCnt;
      end
   end

   // Address register runs one word ahead of the output in bursts.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         arrayAddr <= 16'h0000;
      end else if (startBurst) begin
         arrayAddr <= addrS;
      end else if (loadWord && arrayRead) begin
         // R19 step in order; non-array reads repeat one word.
         arrayAddr <= stepAddr;
      end else if (!syncMode) begin
         arrayAddr <= addrS;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dataOut <= 16'h0000;
      end else if (!syncMode && busRead) begin
         dataOut <= srcData;
      end else if (loadWord) begin
         dataOut <= srcData;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dataOe  <= 1'b0;
         stallOe <= 1'b0;
      end else begin
         dataOe  <= busRead;
         // R10 float the stall pin unless chip select and output enable are both low.
         stallOe <= stallPinOn;
      end
   end

   // Stall level register; polarity applied when loaded.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stallOut <= 1'b0;
      end else if (!stallPinOn) begin
         stallOut <= stallIdle;
      end else if (!syncMode) begin
         // R9 asynchronous reads keep stall deasserted.
         stallOut <= stallLevelOff;
      end else if (activeEdge) begin
         // R7 stall moves only on active edges of a bus cycle.
         stallOut <= stallWant ? stallLevelOn : stallLevelOff;
      end
   end

endmodule : fbr_flash_read_cfg

/* fbr_pkg.sv */
// Shared constants and types for the flash burst read configuration block.
package fbr_pkg;

   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned PIN_W  = 37;

   // Commands seen on the low data byte of a bus write.
   localparam logic [7:0] CMD_CFG_SETUP  = 8'h60;
   localparam logic [7:0] CMD_CFG_WRITE  = 8'h03;
   localparam logic [7:0] CMD_READ_IDENT = 8'h90;
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;

   // Identifier space offset of the read_config register.
   localparam logic [ADDR_W-1:0] ID_CFG_OFFSET = 16'h0005;
   // Value returned at other identifier offsets; arbitrary.
   localparam logic [DATA_W-1:0] ID_FILL       = 16'h0000;

   localparam logic [15:0] CFG_RESET     = 16'hBFCF;
   localparam logic [15:0] CFG_KEEP_MASK = 16'hBFCF;

   localparam int unsigned MODE_BIT  = 15;
   localparam int unsigned LAT_HI    = 13;
   localparam int unsigned LAT_LO    = 11;
   localparam int unsigned POL_BIT   = 10;
   localparam int unsigned HOLD_BIT  = 9;
   localparam int unsigned LEAD_BIT  = 8;
   localparam int unsigned ORDER_BIT = 7;
   localparam int unsigned EDGE_BIT  = 6;
   localparam int unsigned WRAP_BIT  = 3;
   localparam int unsigned LEN_HI    = 2;
   localparam int unsigned LEN_LO    = 0;

   localparam logic [2:0] LAT_MIN_CODE  = 3'h2;
   localparam logic [2:0] LAT_RATE_CODE = 3'h3;
   localparam logic [2:0] LEN_4         = 3'h1;
   localparam logic [2:0] LEN_8         = 3'h2;
   localparam logic [2:0] LEN_16        = 3'h3;
   localparam logic [1:0] GROUP_LAST    = 2'h3;

   // Idle levels of the synchronised pins after reset.
   localparam logic [PIN_W-1:0] PIN_RESET = 37'h0F_0000_0000;

   typedef enum {CMD_ARRAY, CMD_IDENT, CMD_SETUP} fbr_cmd_t;
   typedef enum {BR_IDLE, BR_RUN, BR_DONE} fbr_burst_t;

endpackage : fbr_pkg

/* fbr_pin_sync.sv */
// Two-stage synchroniser for a vector of asynchronous pins.
`timescale 1ns/1ps
module fbr_pin_sync #(
   parameter int unsigned     W    = 1,
   parameter logic [W-1:0]    INIT = '0
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] pinRaw,
   output logic      [W-1:0] pinSync
);

   logic [W-1:0] stageOne;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : gBit
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               stageOne[i] <= INIT[i];
               pinSync[i]  <= INIT[i];
            end else begin
               stageOne[i] <= pinRaw[i];
               pinSync[i]  <= stageOne[i];
            end
         end
      end
   endgenerate

endmodule : fbr_pin_sync

/* fbr_burst_step.sv */
// Next burst word address, linear or wrapped within the burst block.
`timescale 1ns/1ps
module fbr_burst_step (
   input  wire logic [15:0] curAddr,
   input  wire logic        wrapOn,
   input  wire logic [2:0]  lenCode,
   output logic      [15:0] nextAddr,
   output logic      [3:0]  lenMask
);

   logic [15:0] linearAddr;
   logic [15:0] wideMask;

   // R20 continuous bursts get no mask and run linearly.
   assign lenMask = (lenCode == fbr_pkg::LEN_4)  ? 4'h3 :
                    (lenCode == fbr_pkg::LEN_8)  ? 4'h7 :
                    (lenCode == fbr_pkg::LEN_16) ? 4'hF : 4'h0;

   assign linearAddr = curAddr + 16'h0001;
   assign wideMask   = {12'h000, lenMask};

   // R19 wrap keeps the upper bits and counts modulo the length.
   assign nextAddr = (wrapOn && lenMask != 4'h0) ?
                     ((curAddr & ~wideMask) | (linearAddr & wideMask)) :
                     linearAddr;

endmodule : fbr_burst_step

/* fbr_flash_read_cfg_monitor.sv */
// Port-level checks on the flash burst read configuration block.
`timescale 1ns/1ps
module fbr_flash_read_cfg_monitor (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        flashClk,
   input wire logic        chipSelN,
   input wire logic        outEnN,
   input wire logic        writeEnN,
   input wire logic        dataOe,
   input wire logic        stallOut,
   input wire logic        stallOe,
   input wire logic [15:0] readConfig
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   cfg_reserved_a:
      assert property ((readConfig & ~fbr_pkg::CFG_KEEP_MASK) == 16'h0000)
      else $error("reserved config bits set");
   cfg_default_a:
      assert property (!$past(rst_b) |-> readConfig == fbr_pkg::CFG_RESET)
      else $error("config not default after reset");
   cfg_hold_a:
      assert property (writeEnN [*8] |-> $stable(readConfig))
      else $error("config changed without a write");
   pins_float_a:
      assert property ((chipSelN || outEnN) [*5] |-> !dataOe && !stallOe)
      else $error("pin driven while deselected");
   pins_drive_a:
      assert property ((!chipSelN && !outEnN && writeEnN) [*5]
                       |-> dataOe && stallOe)
      else $error("pin not driven in read cycle");
   write_float_a:
      assert property ((!writeEnN) [*5] |-> !dataOe)
      else $error("data driven during write");
   async_level_a:
      assert property (readConfig[15] && stallOe |-> stallOut == !readConfig[10])
      else $error("stall asserted in async read");
   stall_edge_a:
      assert property ((stallOe && $stable(flashClk)) [*6] ##1 stallOe
                       |-> $stable(stallOut))
      else $error("stall moved without a clock edge");
endmodule : fbr_flash_read_cfg_monitor

bind fbr_flash_read_cfg fbr_flash_read_cfg_monitor u_mon (
   .clk(clk), .rst_b(rst_b), .flashClk(flashClk), .chipSelN(chipSelN),
   .outEnN(outEnN), .writeEnN(writeEnN), .dataOe(dataOe),
   .stallOut(stallOut), .stallOe(stallOe), .readConfig(readConfig)
);

/* fbr_array_model.sv */
// Array memory model answering each word address with the address XOR a fixed pattern.
`timescale 1ns/1ps
module fbr_array_model #(
   parameter logic [15:0] PATTERN = 16'hA5C3
) (
   input  wire logic [15:0] arrayAddr,
   output logic      [15:0] arrayData
);
   assign arrayData = arrayAddr ^ PATTERN;
endmodule : fbr_array_model

/* tb_fbr_flash_read_cfg.sv */
// Self-checking bench for the flash burst read configuration block.
`timescale 1ns/1ps
module tb_fbr_flash_read_cfg;
   localparam logic [15:0] PAT = 16'hA5C3;
   localparam logic [2:0]  LENS [0:5] = '{3'h1, 3'h2, 3'h3, 3'h7, 3'h1, 3'h3};
   logic        clk, rst_b, flashClk, chipSelN, outEnN, writeEnN;
   logic        addrValidN, dataOe, stallOut, stallOe, w;
   logic [15:0] addrIn, dataIn, arrayData, arrayAddr, dataOut;
   logic [15:0] readConfig, q, v;
   logic [15:0] d [0:15];
   logic        s [0:15];
   int          n_mismatch = 0;
   int          samples_checked = 0;
   int          cycles = 0;

   fbr_flash_read_cfg DUT (
      .clk(clk), .rst_b(rst_b), .flashClk(flashClk), .chipSelN(chipSelN),
      .outEnN(outEnN), .writeEnN(writeEnN), .addrValidN(addrValidN),
      .addrIn(addrIn), .dataIn(dataIn), .arrayData(arrayData),
      .arrayAddr(arrayAddr), .dataOut(dataOut), .dataOe(dataOe),
      .stallOut(stallOut), .stallOe(stallOe), .readConfig(readConfig)
   );
   fbr_array_model #(.PATTERN(PAT)) mem (
      .arrayAddr(arrayAddr), .arrayData(arrayData)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   task automatic chk_word(input string nm, input logic [15:0] e,
                           input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_word

   task automatic chk_bit(input string nm, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %b seen %b", nm, e, g);
      end
   endtask : chk_bit

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish

   // Command write: low byte of the data bus carries the command.
   task automatic wr(input logic [15:0] a, input logic [7:0] c);
      @(posedge clk) begin
         chipSelN <= 1'b0;
         writeEnN <= 1'b0;
         addrIn   <= a;
         dataIn   <= {8'h00, c};
      end
      tick(6);
      writeEnN <= 1'b1;
      tick(4);
      chipSelN <= 1'b1;
      tick(4);
   endtask : wr

   task automatic cfg(input logic [15:0] val);
      wr(val, 8'h60);
      wr(val, 8'h03);
   endtask : cfg

   task automatic rd(input logic [15:0] a);
      @(posedge clk) begin
         chipSelN   <= 1'b0;
         outEnN     <= 1'b0;
         addrValidN <= 1'b0;
         addrIn     <= a;
      end
      tick(8);
      q = dataOut;
      w = stallOut;
      chipSelN   <= 1'b1;
      outEnN     <= 1'b1;
      addrValidN <= 1'b1;
      tick(4);
   endtask : rd

   // Address captured on the address-valid rise, then n link clocks.
   task automatic burst(input logic [15:0] a, input int n);
      @(posedge clk) begin
         chipSelN   <= 1'b0;
         outEnN     <= 1'b0;
         addrValidN <= 1'b0;
         addrIn     <= a;
      end
      tick(6);
      addrValidN <= 1'b1;
      tick(6);
      for (int i = 0; i < n; i++) begin
         flashClk <= 1'b1;
         tick(8);
         flashClk <= 1'b0;
         tick(8);
         d[i] = dataOut;
         s[i] = stallOut;
      end
      chipSelN <= 1'b1;
      outEnN   <= 1'b1;
      tick(6);
   endtask : burst

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   initial begin
      {rst_b, flashClk, dataIn, addrIn} = '0;
      {chipSelN, outEnN, writeEnN, addrValidN} = 4'hF;
      tick(20);
      rst_b <= 1'b1;
      tick(4);
      chk_word("config reset", 16'hBFCF, readConfig);
      rd(16'h0123);
      chk_word("async data", 16'h0123 ^ PAT, q);
      chk_bit("async stall", 1'b0, w);
      wr(16'h0000, 8'h90);
      rd(16'h0005);
      chk_word("ident config", 16'hBFCF, q);
      rd(16'h0006);
      chk_word("ident other", fbr_pkg::ID_FILL, q);
      wr(16'h0000, 8'h60);
      wr(16'h0000, 8'h90);
      chk_word("config kept", 16'hBFCF, readConfig);
      rd(16'h0005);
      chk_word("array after abort", 16'h0005 ^ PAT, q);
      $display("test identifier and abort done");
      for (int j = 0; j < 6; j++) begin
         v = {2'b10, 3'(j + 2), 8'hD9, LENS[j]};
         cfg(v);
         chk_word("config load", v, readConfig);
      end
      $display("test config codes done");
      cfg(16'h5CF1);
      chk_word("config masked", 16'h1CC1, readConfig);
      burst(16'h0002, 6);
      chk_bit("stall before data", 1'b1, s[1]);
      chk_bit("stall with data", 1'b0, s[2]);
      for (int i = 0; i < 4; i++)
         chk_word("wrap word", (16'(2 + i) & 16'h0003) ^ PAT, d[2 + i]);
      $display("test wrapped burst done");
      cfg(16'h2887);
      burst(16'h000E, 11);
      chk_bit("low stall on", 1'b0, s[3]);
      chk_bit("low stall off", 1'b1, s[4]);
      for (int i = 0; i < 4; i++)
         chk_word("linear word", 16'(14 + i) ^ PAT, d[4 + i]);
      chk_bit("stall in gap", 1'b0, s[8]);
      chk_word("word after gap", 16'h0012 ^ PAT, d[10]);
      $display("test continuous burst done");
      cfg(16'h27CA);
      burst(16'h0006, 9);
      chk_bit("early stall on", 1'b1, s[0]);
      chk_bit("early stall off", 1'b0, s[2]);
      chk_word("first word", 16'h0006 ^ PAT, d[3]);
      chk_word("held word", 16'h0006 ^ PAT, d[4]);
      chk_word("next word", 16'h0007 ^ PAT, d[5]);
      chk_word("unwrapped word", 16'h0008 ^ PAT, d[7]);
      $display("test two-clock hold done");
      wr(16'h0000, 8'h90);
      rst_b <= 1'b0;
      tick(3);
      rst_b <= 1'b1;
      tick(4);
      chk_word("config after reset", 16'hBFCF, readConfig);
      rd(16'h0040);
      chk_word("async after reset", 16'h0040 ^ PAT, q);
      $display("test second reset done");
      tally_and_finish();
   end
endmodule : tb_fbr_flash_read_cfg
